// ### irq_reporter_cfg.svh
// Constants for the host interrupt reporter
`ifndef IRQ_REPORTER_CFG_SVH
`define IRQ_REPORTER_CFG_SVH
`define SYS_SRC_W     8
`define EVT_W         8
`define EVT_DEPTH     8
`define EVT_PTR_W     3
`define EVT_CNT_W     4
`define QUEUE_COUNT   3
`define KIND_NONE     2'h0
`define KIND_SYS      2'h1
`define KIND_EVT      2'h2
`define MASK_RESET    8'hFF
`endif

// ### irq_reporter_pkg.sv
// Types for the host interrupt reporter
`include "irq_reporter_cfg.svh"
package irq_reporter_pkg;
  typedef logic [1:0] report_kind_t;
  typedef logic [`EVT_W-1:0] evt_word_t;
endpackage

// ### irq_reporter.sv
// Prioritised host interrupt reporter with system sources and three event queues
`include "irq_reporter_cfg.svh"
module irq_reporter
  import irq_reporter_pkg::*;
(
  input  wire logic                  CLK,          // Core clock, 20 MHz
  input  wire logic                  SRST,         // Synchronous reset, active high
  input  wire logic [`SYS_SRC_W-1:0] SYS_SET,      // System source set pulses
  input  wire logic [`SYS_SRC_W-1:0] SYS_MASK,     // Per-source enable, 1 = enabled
  input  wire logic                  EVENT_DELAY,  // Defer queues 2 and 3
  input  wire logic [2:0]            EVT_PUSH,     // Event push strobe per queue
  input  wire evt_word_t             EVT_DATA,     // Event code pushed
  input  wire logic                  IND_READ,     // Host reads indication register
  output logic                       INT_N,        // Host interrupt, active low
  output report_kind_t               IND_KIND,     // Kind of item in last read
  output logic [1:0]                 IND_QUEUE,    // Queue of reported event
  output logic [`SYS_SRC_W-1:0]      IND_SYS,      // System bits reported
  output evt_word_t                  IND_EVT,      // Event code reported
  output logic [2:0]                 EVT_FULL,     // Queue full flags
  output logic [`SYS_SRC_W-1:0]      SYS_STATUS    // Raw system source register
);

  // Event queue storage, one array per priority
  evt_word_t                 mem_reg [`QUEUE_COUNT][`EVT_DEPTH];
  logic [`EVT_PTR_W-1:0]     wr_reg  [`QUEUE_COUNT];  // Write pointers
  logic [`EVT_PTR_W-1:0]     rd_reg  [`QUEUE_COUNT];  // Read pointers
  logic [`EVT_CNT_W-1:0]     cnt_reg [`QUEUE_COUNT];  // Fill counts
  logic [`SYS_SRC_W-1:0]     sys_reg;                 // Sticky system sources
  logic [`SYS_SRC_W-1:0]     sys_live;                // Unmasked sources
  logic [2:0]                q_ne;                    // Queue nonempty
  logic                      sys_pend;                // Any unmasked system bit
  logic                      req_next;                // Combined request
  logic [2:0]                pop;                     // Queue retired by a read
  logic                      sys_ack;                 // System bits retired by a read

  // Nonempty test for one queue
  function automatic logic nonempty(input logic [`EVT_CNT_W-1:0] c);
    nonempty = (c != '0);
  endfunction

  // Pending terms and priority of the reported item
  always_comb begin
    sys_live = sys_reg & SYS_MASK;
    sys_pend = |sys_live;
    for (int i = 0; i < `QUEUE_COUNT; i++) begin
      q_ne[i] = nonempty(cnt_reg[i]);
    end
    // Deferral lets queues 2/3 ride only on higher work
    if (EVENT_DELAY) begin
      req_next = sys_pend | q_ne[0];
    end else begin
      req_next = sys_pend | (|q_ne);
    end
    pop     = 3'h0;
    sys_ack = 1'b0;
    if (IND_READ) begin
      if (sys_pend) begin
        sys_ack = 1'b1;
      end else if (q_ne[0]) begin
        pop[0] = 1'b1;
      end else if (q_ne[1]) begin
        pop[1] = 1'b1;
      end else if (q_ne[2]) begin
        pop[2] = 1'b1;
      end
    end
  end

  // System source register: set wins over acknowledge clear
  always_ff @(posedge CLK) begin
    if (SRST) begin
      sys_reg <= '0;
    end else if (sys_ack) begin
      sys_reg <= (sys_reg & ~sys_live) | SYS_SET;
    end else begin
      sys_reg <= sys_reg | SYS_SET;
    end
  end

  // Three FIFO queues, pushes and pops may coincide
  always_ff @(posedge CLK) begin
    for (int i = 0; i < `QUEUE_COUNT; i++) begin
      if (SRST) begin
        wr_reg[i]  <= '0;
        rd_reg[i]  <= '0;
        cnt_reg[i] <= '0;
      end else begin
        // Push is dropped when full and not popping
        if (EVT_PUSH[i] && (cnt_reg[i] != `EVT_CNT_W'(`EVT_DEPTH) || pop[i])) begin
          mem_reg[i][wr_reg[i]] <= EVT_DATA;
          wr_reg[i] <= wr_reg[i] + `EVT_PTR_W'(1);
        end
        if (pop[i]) begin
          rd_reg[i] <= rd_reg[i] + `EVT_PTR_W'(1);
        end
        // Count tracks accepted pushes minus pops
        if (EVT_PUSH[i] && !pop[i] && cnt_reg[i] != `EVT_CNT_W'(`EVT_DEPTH)) begin
          cnt_reg[i] <= cnt_reg[i] + `EVT_CNT_W'(1);
        end else if (pop[i] && !EVT_PUSH[i]) begin
          cnt_reg[i] <= cnt_reg[i] - `EVT_CNT_W'(1);
        end
      end
    end
  end

  // Indication register contents captured on each read
  always_ff @(posedge CLK) begin
    if (SRST) begin
      IND_KIND  <= `KIND_NONE;
      IND_QUEUE <= 2'h0;
      IND_SYS   <= '0;
      IND_EVT   <= '0;
    end else if (IND_READ) begin
      IND_SYS <= sys_live;
      if (sys_ack) begin
        IND_KIND  <= `KIND_SYS;
        IND_QUEUE <= 2'h0;
        IND_EVT   <= '0;
      end else if (|pop) begin
        IND_KIND <= `KIND_EVT;
        IND_SYS  <= '0;
        if (pop[0]) begin
          IND_QUEUE <= 2'h1;
          IND_EVT   <= mem_reg[0][rd_reg[0]];
        end else if (pop[1]) begin
          IND_QUEUE <= 2'h2;
          IND_EVT   <= mem_reg[1][rd_reg[1]];
        end else begin
          IND_QUEUE <= 2'h3;
          IND_EVT   <= mem_reg[2][rd_reg[2]];
        end
      end else begin
        IND_KIND  <= `KIND_NONE;
        IND_QUEUE <= 2'h0;
        IND_EVT   <= '0;
      end
    end
  end

  // Registered interrupt pin, low while a request stands
  always_ff @(posedge CLK) begin
    if (SRST) begin
      INT_N <= 1'b1;
    end else begin
      INT_N <= ~req_next;
    end
  end

  // Status mirrors
  always_ff @(posedge CLK) begin
    if (SRST) begin
      EVT_FULL   <= 3'h0;
      SYS_STATUS <= '0;
    end else begin
      for (int i = 0; i < `QUEUE_COUNT; i++) begin
        EVT_FULL[i] <= (cnt_reg[i] == `EVT_CNT_W'(`EVT_DEPTH));
      end
      SYS_STATUS <= sys_reg;
    end
  end

  // Pin follows the request one edge later
  chk_pin_tracks_req: assert property (@(posedge CLK) disable iff (SRST)
    1'b1 |=> INT_N == !$past(req_next))
    else $error("interrupt pin does not follow request");
  // Masked-only system bits never pull the pin low
  chk_mask_blocks: assert property (@(posedge CLK) disable iff (SRST)
    (!sys_pend && q_ne == 3'h0) |=> INT_N)
    else $error("pin low with nothing unmasked pending");
  // Deferred low queues alone keep the pin high
  chk_defer_holds: assert property (@(posedge CLK) disable iff (SRST)
    (EVENT_DELAY && !sys_pend && !q_ne[0]) |=> INT_N)
    else $error("deferred queue raised interrupt");
  // Nonempty queue without deferral pulls the pin low
  chk_queue_asserts: assert property (@(posedge CLK) disable iff (SRST)
    (!EVENT_DELAY && q_ne != 3'h0) |=> !INT_N)
    else $error("pending event did not assert pin");
  // System bits go before any event
  chk_sys_first: assert property (@(posedge CLK) disable iff (SRST)
    (IND_READ && sys_pend) |=> IND_KIND == `KIND_SYS)
    else $error("event reported ahead of system");
  // Queue 1 served ahead of lower queues
  chk_queue_order: assert property (@(posedge CLK) disable iff (SRST)
    (IND_READ && !sys_pend && q_ne[0]) |=> IND_QUEUE == 2'h1)
    else $error("queue 1 not served first");
  // One read retires at most one queue entry
  chk_single_pop: assert property (@(posedge CLK) disable iff (SRST)
    $onehot0(pop) && !(sys_ack && |pop))
    else $error("more than one item retired");
  // Popped count drops by one without a push
  chk_count_drop: assert property (@(posedge CLK) disable iff (SRST)
    (pop[0] && !EVT_PUSH[0]) |=> cnt_reg[0] == $past(cnt_reg[0]) - `EVT_CNT_W'(1))
    else $error("queue count not decremented");
  // Pin stays low on the edge after a read while the request stands
  chk_stays_low: assert property (@(posedge CLK) disable iff (SRST)
    (IND_READ && !INT_N && req_next) |=> !INT_N)
    else $error("pin released while work pending");

  // Further guards on flags, queues, the pin and the indication register
  // A set pulse always lands, even on an acknowledge edge
  chk_set_wins: assert property (@(posedge CLK) disable iff (SRST)
    (SYS_SET != '0) |=> ((sys_reg & $past(SYS_SET)) == $past(SYS_SET)))
    else $error("system set lost");
  // Acknowledge clears reported bits not set again
  chk_sys_clear: assert property (@(posedge CLK) disable iff (SRST)
    sys_ack |=> ((sys_reg & $past(sys_live) & ~$past(SYS_SET)) == '0))
    else $error("reported system bits not cleared");
  // Bits outside the reported set are kept
  chk_masked_kept: assert property (@(posedge CLK) disable iff (SRST)
    1'b1 |=> ((sys_reg & ~$past(sys_live)) ==
              (($past(sys_reg) | $past(SYS_SET)) & ~$past(sys_live))))
    else $error("unreported system bits changed");
  // Event read carries no system bits
  chk_evt_kind: assert property (@(posedge CLK) disable iff (SRST)
    (IND_READ && !sys_pend && q_ne != 3'h0) |=> (IND_KIND == `KIND_EVT && IND_SYS == '0))
    else $error("event report malformed");
  // Read with nothing pending reports none
  chk_none_kind: assert property (@(posedge CLK) disable iff (SRST)
    (IND_READ && !sys_pend && q_ne == 3'h0) |=> IND_KIND == `KIND_NONE)
    else $error("empty read reported an item");
  // Queue 2 served when queue 1 is empty
  chk_queue_two: assert property (@(posedge CLK) disable iff (SRST)
    (IND_READ && !sys_pend && !q_ne[0] && q_ne[1]) |=> IND_QUEUE == 2'h2)
    else $error("queue 2 not served");
  // Queue 3 served last
  chk_queue_three: assert property (@(posedge CLK) disable iff (SRST)
    (IND_READ && !sys_pend && q_ne[1:0] == 2'h0 && q_ne[2]) |=> IND_QUEUE == 2'h3)
    else $error("queue 3 not served");
  // Unmasked system work pulls the pin low
  chk_sys_asserts: assert property (@(posedge CLK) disable iff (SRST)
    sys_pend |=> !INT_N)
    else $error("system interrupt did not assert pin");
  // Deferral lets higher work pull the pin low
  chk_defer_release: assert property (@(posedge CLK) disable iff (SRST)
    (EVENT_DELAY && (sys_pend || q_ne[0])) |=> !INT_N)
    else $error("deferral blocked higher work");
  // Full flag follows a full queue
  chk_full_flag: assert property (@(posedge CLK) disable iff (SRST)
    (cnt_reg[0] == `EVT_CNT_W'(`EVT_DEPTH)) |=> EVT_FULL[0])
    else $error("full flag missing");
  // Counts never pass the depth
  chk_count_bound: assert property (@(posedge CLK) disable iff (SRST)
    cnt_reg[0] <= `EVT_CNT_W'(`EVT_DEPTH) && cnt_reg[1] <= `EVT_CNT_W'(`EVT_DEPTH)
    && cnt_reg[2] <= `EVT_CNT_W'(`EVT_DEPTH))
    else $error("queue count over depth");
  // Accepted push without a pop raises the count
  chk_count_rise: assert property (@(posedge CLK) disable iff (SRST)
    (EVT_PUSH[1] && !pop[1] && cnt_reg[1] != `EVT_CNT_W'(`EVT_DEPTH))
    |=> cnt_reg[1] == $past(cnt_reg[1]) + `EVT_CNT_W'(1))
    else $error("queue count not incremented");
  // Push to a full queue without a pop is dropped
  chk_full_drop: assert property (@(posedge CLK) disable iff (SRST)
    (EVT_PUSH[0] && !pop[0] && cnt_reg[0] == `EVT_CNT_W'(`EVT_DEPTH))
    |=> cnt_reg[0] == `EVT_CNT_W'(`EVT_DEPTH))
    else $error("full queue count changed");
  // Status output mirrors the sticky register
  chk_status_mirror: assert property (@(posedge CLK) disable iff (SRST)
    1'b1 |=> SYS_STATUS == $past(sys_reg))
    else $error("status mirror wrong");
  // Queue 1 read returns its oldest entry
  chk_head_q1: assert property (@(posedge CLK) disable iff (SRST)
    pop[0] |=> IND_EVT == $past(mem_reg[0][rd_reg[0]]))
    else $error("queue 1 head wrong");
  // Queue 2 read returns its oldest entry
  chk_head_q2: assert property (@(posedge CLK) disable iff (SRST)
    pop[1] |=> IND_EVT == $past(mem_reg[1][rd_reg[1]]))
    else $error("queue 2 head wrong");
  // Queue 3 read returns its oldest entry
  chk_head_q3: assert property (@(posedge CLK) disable iff (SRST)
    pop[2] |=> IND_EVT == $past(mem_reg[2][rd_reg[2]]))
    else $error("queue 3 head wrong");
  // Accepted push advances the write pointer
  chk_wr_advance: assert property (@(posedge CLK) disable iff (SRST)
    (EVT_PUSH[2] && cnt_reg[2] != `EVT_CNT_W'(`EVT_DEPTH))
    |=> wr_reg[2] == $past(wr_reg[2]) + `EVT_PTR_W'(1))
    else $error("write pointer stuck");
  // Pop advances the read pointer
  chk_rd_advance: assert property (@(posedge CLK) disable iff (SRST)
    pop[0] |=> rd_reg[0] == $past(rd_reg[0]) + `EVT_PTR_W'(1))
    else $error("read pointer stuck");
  // System read reports every unmasked bit at once
  chk_sys_report: assert property (@(posedge CLK) disable iff (SRST)
    sys_ack |=> IND_SYS == $past(sys_live))
    else $error("system bits misreported");
  // Nothing is retired without a read
  chk_pop_needs_read: assert property (@(posedge CLK) disable iff (SRST)
    (pop != 3'h0 || sys_ack) |-> IND_READ)
    else $error("item retired without read");

  cov_sys_read:   cover property (@(posedge CLK) IND_READ && sys_pend);
  cov_evt_read:   cover property (@(posedge CLK) IND_READ && pop[2]);
  cov_deferred:   cover property (@(posedge CLK) EVENT_DELAY && q_ne[1] && INT_N);
  cov_queue_full: cover property (@(posedge CLK) EVT_FULL[0]);
  cov_set_on_ack: cover property (@(posedge CLK) sys_ack && SYS_SET != '0);

endmodule

// ### host_model.sv
// Host model that services the interrupt line by reading the indication register
module host_model (
  input  wire logic       clk,   // Core clock
  input  wire logic       srst,  // Synchronous reset, active high
  input  wire logic       int_n, // Interrupt line, active low
  input  wire logic       en,    // Host allowed to service
  input  wire logic [3:0] gap,   // Extra idle cycles after a read
  output logic            rd     // Indication read pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_cnt; // Cycles before the line is trusted again
  // Reads repeat while the line stays low; the line lags a read by two edges
  always @(posedge clk) begin
    if (srst) begin
      rd       <= 1'b0;
      wait_cnt <= 0;
    end else if (wait_cnt > 0) begin
      rd       <= 1'b0;
      wait_cnt <= wait_cnt - 1;
    end else if (en && !int_n) begin
      rd       <= 1'b1;
      wait_cnt <= gap + 2;
    end else begin
      rd <= 1'b0;
    end
  end
endmodule

// ### irq_reporter_tb.sv
// Self-checking testbench for the host interrupt reporter
`include "irq_reporter_cfg.svh"
module irq_reporter_tb import irq_reporter_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk, srst, ev_dly, host_en, ind_read, int_n; // Controls and lines
  logic [7:0]   sys_set, sys_mask, sys_stat, ind_sys;        // System source side
  logic [2:0]   push, full;                                  // Queue strobes, flags
  logic [3:0]   gap;                                         // Host slowness
  logic [1:0]   ind_queue;                                   // Reported queue
  report_kind_t ind_kind;                                    // Reported kind
  evt_word_t    ev_data, ind_evt;                            // Event codes
  int           miscompares, checks;                         // Tallies
  irq_reporter irq_reporter_inst (.CLK(clk), .SRST(srst), .SYS_SET(sys_set),
    .SYS_MASK(sys_mask), .EVENT_DELAY(ev_dly), .EVT_PUSH(push), .EVT_DATA(ev_data),
    .IND_READ(ind_read), .INT_N(int_n), .IND_KIND(ind_kind), .IND_QUEUE(ind_queue),
    .IND_SYS(ind_sys), .IND_EVT(ind_evt), .EVT_FULL(full), .SYS_STATUS(sys_stat));
  host_model host_model_inst (.clk(clk), .srst(srst), .int_n(int_n), .en(host_en),
    .gap(gap), .rd(ind_read));
  // Free-running 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Verdict and end of run
  task automatic end_sim();
    if (miscompares == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [7:0] e, g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One-cycle strobes, launched and dropped on edges
  task automatic push_ev(input logic [2:0] q, input evt_word_t d);
    @(posedge clk);
    push    <= q;
    ev_data <= d;
    @(posedge clk);
    push <= 3'h0;
  endtask
  task automatic set_sys(input logic [7:0] s);
    @(posedge clk);
    sys_set <= s;
    @(posedge clk);
    sys_set <= 8'h00;
  endtask
  task automatic chk_int(input logic e);
    @(posedge clk);
    #1;
    cmp("int_n", {7'h00, e}, {7'h00, int_n});
  endtask
  // Wait for the host read, then judge the report it returned
  task automatic get(input report_kind_t k, input logic [1:0] q, input logic [7:0] s, e);
    int n;
    n = 0;
    while (ind_read !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1;
    cmp("kind", {6'h00, k}, {6'h00, ind_kind});
    cmp("queue", {6'h00, q}, {6'h00, ind_queue});
    cmp("sys", s, ind_sys);
    if (k === `KIND_EVT) cmp("evt", e, ind_evt);
  endtask
  // Masked sources stay sticky but silent
  task automatic t_sys();
    sys_mask <= 8'h0F;
    set_sys(8'h3C);
    get(`KIND_SYS, 2'h0, 8'h0C, 8'h00);
    chk_int(1'b1);
    cmp("status", 8'h30, sys_stat);
  endtask
  // System first, then queues 1..3, arrival order inside a queue
  task automatic t_order();
    host_en  <= 1'b0;
    sys_mask <= 8'hFF;
    push_ev(3'h4, 8'h33);
    push_ev(3'h2, 8'h22);
    push_ev(3'h1, 8'h11);
    push_ev(3'h1, 8'h12);
    set_sys(8'h01);
    host_en <= 1'b1;
    get(`KIND_SYS, 2'h0, 8'h31, 8'h00);
    chk_int(1'b0);
    get(`KIND_EVT, 2'h1, 8'h00, 8'h11);
    get(`KIND_EVT, 2'h1, 8'h00, 8'h12);
    get(`KIND_EVT, 2'h2, 8'h00, 8'h22);
    get(`KIND_EVT, 2'h3, 8'h00, 8'h33);
    chk_int(1'b1);
  endtask
  // Deferral holds queue 2 back until deferral is dropped; queue 1 still interrupts
  task automatic t_delay();
    host_en <= 1'b0;
    ev_dly  <= 1'b1;
    push_ev(3'h2, 8'hA2);
    repeat (4) chk_int(1'b1);
    push_ev(3'h1, 8'hB1);
    chk_int(1'b0);
    host_en <= 1'b1;
    get(`KIND_EVT, 2'h1, 8'h00, 8'hB1);
    chk_int(1'b1);
    ev_dly <= 1'b0;
    get(`KIND_EVT, 2'h2, 8'h00, 8'hA2);
    chk_int(1'b1);
  endtask
  // Overfill queue 1; the ninth entry is dropped, slow host drains
  task automatic t_full();
    host_en <= 1'b0;
    for (int i = 0; i < 9; i++) push_ev(3'h1, 8'h40 + 8'(i));
    chk_int(1'b0);
    cmp("full", 8'h01, {5'h00, full});
    gap     <= 4'h3;
    host_en <= 1'b1;
    for (int i = 0; i < 8; i++) get(`KIND_EVT, 2'h1, 8'h00, 8'h40 + 8'(i));
    chk_int(1'b1);
  endtask
  // Reset, then scenarios in sequence
  initial begin
    miscompares = 0;
    checks      = 0;
    srst        = 1'b1;
    sys_set     = 8'h00;
    sys_mask    = 8'h00;
    ev_dly      = 1'b0;
    push        = 3'h0;
    ev_data     = 8'h00;
    host_en     = 1'b1;
    gap         = 4'h0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    chk_int(1'b1);
    t_sys();
    t_order();
    t_delay();
    t_full();
    end_sim();
  end
  // Hang guard, far beyond the expected run length
  initial begin
    #150000;
    miscompares++;
    end_sim();
  end
endmodule
